// file: gpio_params.svh
// Constants for the eight-bit port with alternate functions
// How it works
// - Direction bit 0 input, 1 output
// - Input pin reads back synchronized pin level
// - Output pin drives latch, reads latch back
// - Output pins raise no edge interrupts
// - Group requests are ORed per vector
// - High rising or low falling pin in group masks others
// - Sources 1,2 rise; 3,4 fall detect
// - Peripheral output use overrides direction and data
// - Peripheral drive forces output, proper drive type
// - Peripheral input pin still readable as data
// - Bit 0 outputs CPU clock when selected
// - Bits 1,2 open-drain I2C data, clock
// - Bits 4-7 are interrupt sources one-four
// - Data and direction reset to zero
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH
`define GPIO_WIDTH 8
`define GPIO_RESET_VALUE 8'h00
`define GPIO_BIT_CLKOUT 0
`define GPIO_BIT_TIMER_EXTERNAL_CLOCK 3
`define GPIO_BIT_SDA 1
`define GPIO_BIT_SCL 2
`define GPIO_BIT_CAP1 4
`define GPIO_BIT_CAP2 5
`define GPIO_BIT_CMP1 6
`define GPIO_BIT_CMP2 7
`define GPIO_IRQ_FIRST 4
`define GPIO_IRQ_COUNT 4
`define GPIO_RISE_MASK 4'h3
`define GPIO_SYNC_STAGES 2
`endif

// file: gpio_pkg.sv
// Types for the eight-bit port
package gpio_pkg;
   typedef enum logic {GPIO_DIR_IN, GPIO_DIR_OUT} gpio_dir_t;
   typedef logic [7:0] gpio_byte_t;
endpackage

// file: gpio_sync.sv
// Two-flop synchronizer bank for the pin inputs
module gpio_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Data
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule

// file: gpio_port.sv
// Eight-bit I/O port with direction, latch, edge interrupts and alternate functions
`include "gpio_params.svh"
module gpio_port (
   // Clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Software register side
   input wire logic data_wr_i,
   input wire gpio_pkg::gpio_byte_t data_wdata_i,
   input wire logic dir_wr_i,
   input wire gpio_pkg::gpio_byte_t dir_wdata_i,
   input wire logic irq_en_wr_i,
   input wire logic [3:0] irq_en_wdata_i,
   input wire logic clock_out_select_i,
   input wire logic [3:0] irq_clear_i,
   output gpio_pkg::gpio_byte_t pin_value_latch_o,
   output gpio_pkg::gpio_byte_t dir_o,
   output logic [3:0] edge_irq_enable_reg_o,
   output logic [3:0] irq_pending_o,
   output logic irq_o,
   // Peripheral side
   input wire logic cpu_clock_i,
   input wire logic i2c_enable_i,
   input wire logic sda_drive_low_i,
   input wire logic scl_drive_low_i,
   input wire logic compare_one_out_enable_i,
   input wire logic compare_two_out_enable_i,
   input wire logic timer_compare_one_i,
   input wire logic timer_compare_two_i,
   output logic timer_capture_one_o,
   output logic timer_capture_two_o,
   output logic timer_external_clock_o,
   output logic sda_in_o,
   output logic scl_in_o,
   // Pins
   input wire gpio_pkg::gpio_byte_t pin_i,
   output gpio_pkg::gpio_byte_t pin_o,
   output gpio_pkg::gpio_byte_t pin_oe_o
);
   import gpio_pkg::*;

   gpio_byte_t data_latch;
   gpio_byte_t dir;
   gpio_byte_t pin_sync;
   gpio_byte_t pin_prev;
   logic [3:0] irq_en;
   logic [3:0] irq_pend;
   logic [3:0] src_level;
   logic [3:0] src_prev;
   logic [3:0] src_edge;
   logic [3:0] next_pend;
   gpio_byte_t next_pin;
   gpio_byte_t next_oe;
   logic group_level;

   // ==========================================
   // Pin synchronizer
   gpio_sync #(.WIDTH(`GPIO_WIDTH)) u_sync (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .async_i(pin_i),
      .sync_o(pin_sync)
   );

   // ==========================================
   // Software registers
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         data_latch <= `GPIO_RESET_VALUE;
      end else if (data_wr_i) begin
         data_latch <= data_wdata_i;
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dir <= `GPIO_RESET_VALUE;
      end else if (dir_wr_i) begin
         dir <= dir_wdata_i;
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_en <= '0;
      end else if (irq_en_wr_i) begin
         irq_en <= irq_en_wdata_i;
      end
   end

   // ==========================================
   // Read-back: latch for outputs, pin for inputs
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_value_latch_o <= '0;
      end else begin
         for (int i = 0; i < `GPIO_WIDTH; i++) begin
            if (dir[i] == GPIO_DIR_OUT) begin
               pin_value_latch_o[i] <= data_latch[i];
            end else begin
               pin_value_latch_o[i] <= pin_sync[i];
            end
         end
      end
   end

   assign dir_o = dir;
   assign edge_irq_enable_reg_o = irq_en;

   // ==========================================
   // Pin drive with alternate function override
   always_comb begin
      for (int i = 0; i < `GPIO_WIDTH; i++) begin
         next_pin[i] = data_latch[i];
         next_oe[i] = dir[i];
      end
      if (clock_out_select_i) begin
         next_pin[`GPIO_BIT_CLKOUT] = cpu_clock_i;
         next_oe[`GPIO_BIT_CLKOUT] = 1'b1;
      end
      if (i2c_enable_i) begin
         // Open drain: only drive low
         next_pin[`GPIO_BIT_SDA] = 1'b0;
         next_oe[`GPIO_BIT_SDA] = sda_drive_low_i;
         next_pin[`GPIO_BIT_SCL] = 1'b0;
         next_oe[`GPIO_BIT_SCL] = scl_drive_low_i;
      end else begin
         // Open-drain pads even as plain outputs
         next_pin[`GPIO_BIT_SDA] = 1'b0;
         next_oe[`GPIO_BIT_SDA] = dir[`GPIO_BIT_SDA] & ~data_latch[`GPIO_BIT_SDA];
         next_pin[`GPIO_BIT_SCL] = 1'b0;
         next_oe[`GPIO_BIT_SCL] = dir[`GPIO_BIT_SCL] & ~data_latch[`GPIO_BIT_SCL];
      end
      if (compare_one_out_enable_i) begin
         next_pin[`GPIO_BIT_CMP1] = timer_compare_one_i;
         next_oe[`GPIO_BIT_CMP1] = 1'b1;
      end
      if (compare_two_out_enable_i) begin
         next_pin[`GPIO_BIT_CMP2] = timer_compare_two_i;
         next_oe[`GPIO_BIT_CMP2] = 1'b1;
      end
   end

   // Clock output path kept combinational to pass the clock
   assign pin_o = next_pin;
   assign pin_oe_o = next_oe;

   // ==========================================
   // Peripheral inputs from synchronized pins
   assign timer_capture_one_o = pin_sync[`GPIO_BIT_CAP1];
   assign timer_capture_two_o = pin_sync[`GPIO_BIT_CAP2];
   assign timer_external_clock_o = pin_sync[`GPIO_BIT_TIMER_EXTERNAL_CLOCK];
   assign sda_in_o = pin_sync[`GPIO_BIT_SDA];
   assign scl_in_o = pin_sync[`GPIO_BIT_SCL];

   // ==========================================
   // Edge interrupt sources on bits 4 to 7
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_prev <= '0;
      end else begin
         pin_prev <= pin_sync;
      end
   end

   // Edge sense of each source, rising or falling
   function automatic logic src_rises(input int k);
      logic [3:0] mask;
      mask = `GPIO_RISE_MASK;
      return mask[k];
   endfunction

   // Source level: high when source would request; rising sources
   // use pin level, falling ones inverted. Output pins read idle.
   always_comb begin
      for (int k = 0; k < `GPIO_IRQ_COUNT; k++) begin
         if (src_rises(k)) begin
            src_level[k] = pin_sync[`GPIO_IRQ_FIRST + k];
            src_prev[k] = pin_prev[`GPIO_IRQ_FIRST + k];
         end else begin
            src_level[k] = ~pin_sync[`GPIO_IRQ_FIRST + k];
            src_prev[k] = ~pin_prev[`GPIO_IRQ_FIRST + k];
         end
         src_level[k] = src_level[k] & irq_en[k] & ~dir[`GPIO_IRQ_FIRST + k];
         src_prev[k] = src_prev[k] & irq_en[k] & ~dir[`GPIO_IRQ_FIRST + k];
         src_edge[k] = src_level[k] & ~src_prev[k];
      end
   end

   // ==========================================
   // Shared vector: ORed levels, so a stuck source masks the rest
   assign group_level = |src_level;

   logic group_prev;
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         group_prev <= 1'b0;
      end else begin
         group_prev <= group_level;
      end
   end

   // ==========================================
   // Pending per source; set wins over clear
   always_comb begin
      for (int k = 0; k < `GPIO_IRQ_COUNT; k++) begin
         next_pend[k] = (irq_pend[k] & ~irq_clear_i[k]) |
            (src_edge[k] & group_level & ~group_prev);
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_pend <= '0;
      end else begin
         irq_pend <= next_pend;
      end
   end

   assign irq_pending_o = irq_pend;
   assign irq_o = |irq_pend;
endmodule

// file: bpwaf_chk.sv
// Concurrent checks on the port boundary
module bpwaf_chk (
   // Clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Software side
   input wire logic dir_wr_i,
   input wire gpio_pkg::gpio_byte_t dir_wdata_i,
   input wire logic [3:0] irq_clear_i,
   input wire gpio_pkg::gpio_byte_t dir_o,
   input wire gpio_pkg::gpio_byte_t pin_value_latch_o,
   input wire logic [3:0] irq_pending_o,
   input wire logic irq_o,
   // Peripheral side
   input wire logic clock_out_select_i,
   input wire logic cpu_clock_i,
   input wire logic i2c_enable_i,
   input wire logic sda_drive_low_i,
   input wire logic compare_one_out_enable_i,
   input wire logic timer_compare_one_i,
   // Pins
   input wire gpio_pkg::gpio_byte_t pin_o,
   input wire gpio_pkg::gpio_byte_t pin_oe_o,
   input wire gpio_pkg::gpio_byte_t pin_i
);
   import gpio_pkg::*;
   // ==========
   // Assertions
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   dir_write_a: assert property (dir_wr_i |=> dir_o == $past(dir_wdata_i))
      else $error("direction write lost");
   oe_follow_a: assert property (pin_oe_o[5:3] == dir_o[5:3])
      else $error("drive enable differs from direction");
   input_read_a: assert property ((!dir_o[3] && $stable(pin_i[3])) [*4]
      |-> pin_value_latch_o[3] == pin_i[3]) else $error("input read-back wrong");
   out_quiet_a: assert property ((&dir_o[7:4]) [*4]
      |-> (irq_pending_o & ~$past(irq_pending_o)) == 4'h0) else $error("request from output pin");
   pend_sticky_a: assert property (
      (irq_pending_o | ~$past(irq_pending_o & ~irq_clear_i)) == 4'hF)
      else $error("pending bit dropped");
   irq_or_a: assert property (irq_o == |irq_pending_o) else $error("request not ORed");
   clk_out_a: assert property (clock_out_select_i
      |-> pin_oe_o[0] && pin_o[0] == cpu_clock_i) else $error("clock output missing");
   i2c_drain_a: assert property (i2c_enable_i
      |-> !pin_o[1] && pin_oe_o[1] == sda_drive_low_i) else $error("data line not open drain");
   cmp_drive_a: assert property (compare_one_out_enable_i
      |-> pin_oe_o[6] && pin_o[6] == timer_compare_one_i) else $error("compare not driven");
   rst_clear_a: assert property (disable iff (1'h0) sys_rst_i
      |-> dir_o == 8'h00 && pin_oe_o == 8'h00 && !irq_o) else $error("reset state wrong");
   cover property (irq_o);
   cover property (clock_out_select_i && cpu_clock_i);
   cover property (dir_o[4] [*4]);
endmodule
bind gpio_port bpwaf_chk bpwaf_chk_i (.*);

// file: bpwaf_board.sv
// Board circuitry on the port pins
module bpwaf_board (
   // Device side
   input wire gpio_pkg::gpio_byte_t pin_o,
   input wire gpio_pkg::gpio_byte_t pin_oe_o,
   // Stimulus side
   input wire gpio_pkg::gpio_byte_t board_val_i,
   input wire gpio_pkg::gpio_byte_t board_en_i,
   // Levels seen by the device
   output gpio_pkg::gpio_byte_t pin_i
);
   import gpio_pkg::*;
   // Device drive wins, released lines rest on pull-ups
   assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & (board_val_i | ~board_en_i));
endmodule

// file: test_bidir_port_with_alt_functions.sv
// Self-checking bench for the eight-bit port
`define BPWAF_CMP(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_bidir_port_with_alt_functions;
   timeunit 1ns;
   timeprecision 100ps;
   import gpio_pkg::*;
   typedef struct {int code; gpio_byte_t mask; gpio_byte_t val;} bpwaf_note_t;
   logic clock_i = 1'h0, sys_rst_i = 1'h0, data_wr_i = 1'h0, dir_wr_i = 1'h0, irq_o;
   logic irq_en_wr_i = 1'h0, clock_out_select_i = 1'h0, cpu_clock_i = 1'h0;
   logic i2c_enable_i = 1'h0, sda_drive_low_i = 1'h0, scl_drive_low_i = 1'h0;
   logic compare_one_out_enable_i = 1'h0, compare_two_out_enable_i = 1'h0;
   logic timer_compare_one_i = 1'h0, timer_compare_two_i = 1'h0;
   logic timer_capture_one_o, timer_capture_two_o, timer_external_clock_o, sda_in_o, scl_in_o;
   logic [3:0] irq_en_wdata_i = 4'h0, irq_clear_i = 4'h0, edge_irq_enable_reg_o, irq_pending_o;
   gpio_byte_t data_wdata_i = 8'h00, dir_wdata_i = 8'h00, bval = 8'h00, bmask = 8'h00;
   gpio_byte_t pin_value_latch_o, dir_o, pin_i, pin_o, pin_oe_o;
   int mismatches = 0, checked = 0;
   logic [31:0] lfsr = 32'hA2278C7B;
   bpwaf_note_t q[$];
   gpio_port gpio_port_i (.*);
   bpwaf_board bpwaf_board_i (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .board_val_i(bval),
      .board_en_i(bmask), .pin_i(pin_i));
   always #12.5 clock_i = ~clock_i;
   always @(posedge clock_i) cpu_clock_i <= ~cpu_clock_i;
   function automatic logic [31:0] next_rand(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic gpio_byte_t obs(int c);
      case (c)
         0: return pin_value_latch_o;
         1: return {3'h0, irq_o, irq_pending_o};
         2: return pin_oe_o;
         3: return pin_o;
         4: return {3'h0, timer_external_clock_o, timer_capture_two_o,
            timer_capture_one_o, scl_in_o, sda_in_o};
         5: return dir_o;
         default: return {4'h0, edge_irq_enable_reg_o};
      endcase
   endfunction
   task automatic tick(int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic note(int c, gpio_byte_t m, gpio_byte_t v);
      q.push_back('{c, m, v});
   endtask
   task automatic wr(int w, gpio_byte_t v);
      data_wdata_i <= v;
      dir_wdata_i <= v;
      irq_en_wdata_i <= v[3:0];
      {data_wr_i, dir_wr_i, irq_en_wr_i} <= {w == 0, w == 1, w == 2};
      tick(1);
      {data_wr_i, dir_wr_i, irq_en_wr_i} <= 3'h0;
      tick(1);
   endtask
   task automatic clr(logic [3:0] m);
      irq_clear_i <= m;
      tick(1);
      irq_clear_i <= 4'h0;
      tick(1);
   endtask
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(negedge clock_i) begin
      bpwaf_note_t n;
      while (q.size() > 0) begin
         n = q.pop_front();
         `BPWAF_CMP(obs(n.code) & n.mask, n.val)
      end
   end
   initial begin
      tick(3000);
      mismatches++;
      give_verdict();
   end
   initial begin
      sys_rst_i <= 1'h1;
      tick(19);
      note(0, 8'hFF, 8'h00);
      note(2, 8'hFF, 8'h00);
      tick(1);
      sys_rst_i <= 1'h0;
      lfsr = next_rand(lfsr);
      {bmask, bval} <= {8'h06, lfsr[15:8]};
      wr(0, lfsr[7:0]);
      wr(1, 8'hF9);
      tick(3);
      note(2, 8'hF9, 8'hF9);
      note(3, 8'hF9, lfsr[7:0] & 8'hF9);
      note(0, 8'hFF, (lfsr[7:0] & 8'hF9) | (lfsr[15:8] & 8'h06));
      note(5, 8'hFF, 8'hF9);
      for (int k = 0; k < 4; k++) begin
         wr(2, 8'h00);
         wr(1, 8'h00);
         {bmask, bval} <= {8'hFF, 8'hC0};
         tick(4);
         clr(4'hF);
         wr(2, 8'h01 << k);
         bval[4 + k] <= k < 2;
         tick(4);
         note(1, 8'h1F, 8'h10 | (8'h01 << k));
         bval[4 + k] <= k > 1;
         tick(4);
         note(1, 8'h1F, 8'h10 | (8'h01 << k));
         clr(4'h1 << k);
         note(1, 8'h1F, 8'h00);
      end
      wr(2, 8'h03);
      bval[4] <= 1'h1;
      tick(4);
      clr(4'h1);
      bval[5] <= 1'h1;
      tick(4);
      note(1, 8'h1F, 8'h00);
      wr(2, 8'h0C);
      note(6, 8'h0F, 8'h0C);
      wr(0, 8'hF0);
      wr(1, 8'hF0);
      wr(0, 8'h0F);
      wr(0, 8'hF0);
      tick(4);
      note(1, 8'h1F, 8'h00);
      wr(2, 8'h00);
      wr(1, 8'h00);
      for (int i = 0; i < 4; i++) begin
         lfsr = next_rand(lfsr);
         bval <= lfsr[7:0];
         tick(4);
         note(0, 8'hFF, lfsr[7:0]);
         note(4, 8'h1F, {lfsr[3], lfsr[5], lfsr[4], lfsr[2], lfsr[1]});
      end
      {clock_out_select_i, i2c_enable_i, sda_drive_low_i, scl_drive_low_i} <= 4'hF;
      {compare_one_out_enable_i, compare_two_out_enable_i, timer_compare_one_i} <= 3'h7;
      tick(4);
      note(2, 8'hC7, 8'hC7);
      note(3, 8'hC6, 8'h40);
      note(4, 8'h03, 8'h00);
      tick(2);
      give_verdict();
   end
endmodule
